/* osc_ctl_pkg.sv */
/*
 * Constants for the oscillator control block: register offsets, field
 * positions, reset values, unlock keys and interrupt bit positions.
 * Assumes a 32-bit register port with byte addresses in word steps.
 */
package osc_ctl_pkg;
    // ======================================================
    // register map
    localparam logic [3:0] OFF_OSC_CTRL = 4'h0;
    localparam logic [3:0] OFF_UNLOCK   = 4'h4;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFF_IRQ_MASK = 4'hC;

    // ======================================================
    // oscillator control fields (low bit of each)
    localparam int POS_PLL_ODIV   = 27;
    localparam int POS_FAST_RC    = 24;
    localparam int POS_SOSC_RDY   = 22;
    localparam int POS_PDIV_RDY   = 21;
    localparam int POS_PERIPH_DIV = 19;
    localparam int POS_PLL_MULT   = 16;
    localparam int POS_NEW_OSC    = 8;
    localparam int POS_SOSC_EN    = 1;

    localparam logic [2:0] FAST_RC_RESET = 3'h1;
    localparam logic [1:0] CFG_PDIV_ERASED = 2'h3;
    localparam logic [2:0] CODE_DIV256 = 3'h7;

    // ======================================================
    // unlock keys: arbitrary values
    localparam logic [31:0] UNLOCK_KEY1 = 32'h3C5A_A5C3;
    localparam logic [31:0] UNLOCK_KEY2 = 32'hC3A5_5A3C;

    // ======================================================
    // interrupt status / mask bits
    localparam int IRQ_W         = 3;
    localparam int IRQ_SOSC_UP   = 0;
    localparam int IRQ_PDIV_DONE = 1;
    localparam int IRQ_LOCK_ERR  = 2;

    typedef enum logic [1:0] {LOCKED, KEY1_SEEN, UNLOCKED} unlock_e;
endpackage : osc_ctl_pkg

/* div_if.sv */
/*
 * Link between the control logic and one power-of-two divider.
 * Assumes both ends run on sys_clk.
 */
`timescale 1ns/10ps
interface div_if;
    logic       tickIn;   // source clock enable
    logic [2:0] code;     // requested division code
    logic       tickOut;  // divided clock enable
    logic [2:0] active;   // code now in use

    modport ctl (output tickIn, output code, input tickOut, input active);
    modport div (input tickIn, input code, output tickOut, output active);
endinterface : div_if

/* clk_div_pow2.sv */
/*
 * Power-of-two clock-enable divider: codes 0..6 divide by 2**code,
 * code 7 by 256. Assumes input ticks synchronous to sys_clk.
 */
`timescale 1ns/10ps
module clk_div_pow2 (
    input wire logic sys_clk,  // system clock
    input wire logic rstn,     // sync reset, active low
    div_if.div       port      // divider link
);
    import osc_ctl_pkg::*;

    // ======================================================
    // terminal count for a code
    function automatic logic [7:0] termOf(input logic [2:0] c);
        logic [8:0] ratio;
        ratio = (c == CODE_DIV256) ? 9'h100 : (9'h001 << c);
        return 8'(ratio - 9'h001);
    endfunction : termOf

    logic [7:0] count_q;
    logic [2:0] active_q;
    logic       tick_q;
    wire        atEnd = port.tickIn && (count_q == termOf(active_q));

    // new code taken only at a period boundary: no short pulse
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            count_q  <= 8'h00;
            active_q <= 3'h0;
            tick_q   <= 1'b0;
        end else begin
            tick_q <= atEnd;
            if (atEnd) begin
                count_q  <= 8'h00;
                active_q <= port.code;
            end else if (port.tickIn) begin
                count_q <= count_q + 8'h01;
            end
        end
    end

    assign port.tickOut = tick_q;
    assign port.active  = active_q;
endmodule : clk_div_pow2

/* osc_ctl.sv */
/*
 * Oscillator control register block: PLL output divider, fast RC
 * divider, peripheral bus divisor with ready flag, secondary oscillator
 * ready, unlock protection and interrupts.
 * Assumes a single-cycle register port and synchronous input ticks.
 */
// Strobed register access and the placing of the registers were chosen for this implementation.
// Behaviour
// RULE1: PLL output divided by 1,2,4,8,16,32,64,256 per bits 29-27.
// RULE2: fast RC clock divided by 1,2,4,8,16,32,64,256 per bits 26-24.
// RULE3: fast RC divider resets to code 001, divide by two.
// RULE4: bit 22 reads one only when secondary oscillator runs stable.
// RULE5: peripheral divisor writes take effect only while bit 21 reads one.
// RULE6: peripheral bus clock is system clock divided by 1,2,4,8 per bits 20-19.
// RULE7: peripheral divisor defaults to code 11, divide by eight.
// RULE8: control writes without the unlock sequence are ignored.
// RULE9: configuration-derived fields load from configuration bits at power-on reset.
// RULE10: bits 31-30 and 23 always read zero.
// RULE11: divisor ready low during a change; new division without short pulses.
`timescale 1ns/10ps
module osc_ctl (
    input  wire logic        sys_clk,       // system clock, 200 MHz
    input  wire logic        rstn,          // sync reset, active low
    input  wire logic [3:0]  addr,          // byte address
    input  wire logic [31:0] wrData,        // write data
    input  wire logic        wrEn,          // write strobe
    input  wire logic        rdEn,          // read strobe
    output logic      [31:0] rdData,        // read data, cycle after rdEn
    input  wire logic [2:0]  cfgPllOdiv,    // config: PLL output divider
    input  wire logic [1:0]  cfgPeriphDiv,  // config: peripheral divisor
    input  wire logic [2:0]  cfgPllMult,    // config: PLL multiplier
    input  wire logic [2:0]  cfgNewOsc,     // config: new oscillator
    input  wire logic        cfgSoscEn,     // config: secondary osc enable
    input  wire logic        pllTick,       // PLL output clock enable
    input  wire logic        fastRcTick,    // fast RC clock enable
    input  wire logic        soscStable,    // secondary osc stable
    output logic             pllClkEn,      // divided PLL clock enable
    output logic             fastRcClkEn,   // divided fast RC enable
    output logic             periphClkEn,   // peripheral bus clock enable
    output logic [2:0]       pllMultiplier, // PLL multiplier code
    output logic [2:0]       newOscSelect,  // requested oscillator
    output logic             soscEnable,    // secondary osc enable
    output logic             irq            // level interrupt
);
    import osc_ctl_pkg::*;

    // ======================================================
    // register state
    logic [2:0]       pll_output_divider_q, fastRcDiv_q, pll_multiplier_q, newOsc_q;
    logic [1:0]       periphDiv_q;
    logic             soscEn_q, secondary_osc_ready_q;
    logic             pdivPend_q;
    logic [IRQ_W-1:0] irqStat_q, irqMask_q;
    logic [31:0]      rdData_q;
    unlock_e          unlock_q, unlock_d;

    div_if pllLink ();
    div_if fastRcLink ();
    div_if periphLink ();

    // ======================================================
    // decode
    wire selCtrl   = (addr == OFF_OSC_CTRL);
    wire selUnlock = (addr == OFF_UNLOCK);
    wire selStat   = (addr == OFF_IRQ_STAT);
    wire selMask   = (addr == OFF_IRQ_MASK);
    wire ctrlWr    = wrEn && selCtrl;
    wire ctrlOk    = ctrlWr && (unlock_q == UNLOCKED);  // [RULE8]
    wire lockErr   = ctrlWr && (unlock_q != UNLOCKED);
    wire periphBusy  = ({1'b0, periphDiv_q} != periphLink.active);
    wire periphRdy   = !periphBusy;                     // [RULE11]
    wire periphWrOk  = ctrlOk && periphRdy;             // [RULE5]
    wire periphStart = periphWrOk && (wrData[POS_PERIPH_DIV +: 2] != periphDiv_q);
    // ready alone cannot tell a finished change from an idle divider
    wire periphDone  = pdivPend_q && periphRdy;         // [RULE11]
    wire soscRdyNow  = soscEn_q && soscStable;          // [RULE4]
    wire soscRise    = soscRdyNow && !secondary_osc_ready_q;

    wire [31:0] ctrlView = {2'b00,                        // [RULE10]
                            pll_output_divider_q, fastRcDiv_q, 1'b0,
                            soscRdyNow, periphRdy, periphDiv_q,
                            pll_multiplier_q, 5'h00, newOsc_q,
                            6'h00, soscEn_q, 1'b0};
    wire [31:0] rdMux = selCtrl   ? ctrlView :
                        selUnlock ? {31'h0, unlock_q == UNLOCKED} :
                        selStat   ? {29'h0, irqStat_q} :
                        selMask   ? {29'h0, irqMask_q} : 32'h0;

    wire [IRQ_W-1:0] irqEvt = {lockErr, periphDone, soscRise};
    wire [IRQ_W-1:0] irqClr = (wrEn && selStat) ? wrData[IRQ_W-1:0] : '0;

    // ======================================================
    // unlock sequence: two keys, then one control write
    always_comb begin
        unlock_d = unlock_q;
        if (ctrlWr) begin
            unlock_d = LOCKED;
        end else if (wrEn && selUnlock) begin
            case (unlock_q)
                LOCKED:    unlock_d = (wrData == UNLOCK_KEY1) ? KEY1_SEEN : LOCKED;
                KEY1_SEEN: unlock_d = (wrData == UNLOCK_KEY2) ? UNLOCKED : LOCKED;
                UNLOCKED:  unlock_d = LOCKED;
                default:   unlock_d = LOCKED;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            unlock_q <= LOCKED;
        end else begin
            unlock_q <= unlock_d;
        end
    end

    // ======================================================
    // control fields; config-derived ones load at reset
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pll_output_divider_q   <= cfgPllOdiv;     // [RULE9]
            periphDiv_q <= cfgPeriphDiv;   // [RULE9] [RULE7]
            pll_multiplier_q   <= cfgPllMult;
            newOsc_q    <= cfgNewOsc;
            soscEn_q    <= cfgSoscEn;
            fastRcDiv_q <= FAST_RC_RESET;  // [RULE3]
        end else if (ctrlOk) begin
            pll_output_divider_q   <= wrData[POS_PLL_ODIV +: 3];
            fastRcDiv_q <= wrData[POS_FAST_RC +: 3];
            pll_multiplier_q   <= wrData[POS_PLL_MULT +: 3];
            newOsc_q    <= wrData[POS_NEW_OSC +: 3];
            soscEn_q    <= wrData[POS_SOSC_EN];
            if (periphWrOk) begin
                periphDiv_q <= wrData[POS_PERIPH_DIV +: 2];
            end
        end
    end

    // ======================================================
    // interrupts: set wins over a same-cycle clear
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            irqStat_q <= '0;
            irqMask_q <= '0;
            secondary_osc_ready_q <= 1'b0;
            pdivPend_q <= 1'b0;
        end else begin
            irqStat_q <= (irqStat_q & ~irqClr) | irqEvt;
            secondary_osc_ready_q <= soscRdyNow;
            // a new change in the completion cycle keeps the flag up
            if (periphStart) begin
                pdivPend_q <= 1'b1;
            end else if (periphDone) begin
                pdivPend_q <= 1'b0;
            end
            if (wrEn && selMask) begin
                irqMask_q <= wrData[IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rdData_q <= 32'h0;
        end else if (rdEn) begin
            rdData_q <= rdMux;
        end
    end

    // ======================================================
    // dividers
    assign pllLink.tickIn    = pllTick;
    assign pllLink.code      = pll_output_divider_q;        // [RULE1]
    assign fastRcLink.tickIn = fastRcTick;
    assign fastRcLink.code   = fastRcDiv_q;      // [RULE2]
    assign periphLink.tickIn = 1'b1;             // system clock every cycle
    assign periphLink.code   = {1'b0, periphDiv_q};  // [RULE6]

    clk_div_pow2 u_pllDiv (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .port    (pllLink)
    );
    clk_div_pow2 u_fastRcDiv (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .port    (fastRcLink)
    );
    clk_div_pow2 u_periphDiv (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .port    (periphLink)
    );

    assign rdData        = rdData_q;
    assign pllClkEn      = pllLink.tickOut;
    assign fastRcClkEn   = fastRcLink.tickOut;
    assign periphClkEn   = periphLink.tickOut;
    assign pllMultiplier = pll_multiplier_q;
    assign newOscSelect  = newOsc_q;
    assign soscEnable    = soscEn_q;
    assign irq           = |(irqStat_q & irqMask_q);

    // ======================================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_fast_rc_reset;
        !$past(rstn) |-> fastRcDiv_q == FAST_RC_RESET;
    endproperty
    a_fast_rc_reset: assert property (p_fast_rc_reset) else $error("fast RC reset code"); // [RULE3]

    property p_cfg_load;
        !$past(rstn) |-> periphDiv_q == $past(cfgPeriphDiv) && pll_output_divider_q == $past(cfgPllOdiv);
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("config load"); // [RULE9] [RULE7]

    property p_zero_bits;
        $past(rdEn && selCtrl) |-> rdData[31:30] == 2'b00 && !rdData[23];
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("reserved bits"); // [RULE10]

    property p_sosc_rdy;
        $past(rdEn && selCtrl) |-> rdData[POS_SOSC_RDY] == $past(soscEn_q && soscStable);
    endproperty
    a_sosc_rdy: assert property (p_sosc_rdy) else $error("osc ready bit"); // [RULE4]

    property p_pdiv_blocked;
        ctrlWr && periphBusy |=> $stable(periphDiv_q);
    endproperty
    a_pdiv_blocked: assert property (p_pdiv_blocked) else $error("divisor write"); // [RULE5]

    property p_locked;
        wrEn && selCtrl && unlock_q != UNLOCKED |=> $stable(fastRcDiv_q) && $stable(pll_output_divider_q);
    endproperty
    a_locked: assert property (p_locked) else $error("locked write"); // [RULE8]

    property p_busy_flag;
        $changed(periphDiv_q) |-> !periphRdy;
    endproperty
    a_busy_flag: assert property (p_busy_flag) else $error("ready flag"); // [RULE11]

    property p_div8;
        periphClkEn && periphLink.active == 3'h3 && periphDiv_q == 2'h3
            |=> (!periphClkEn)[*7] ##1 periphClkEn;
    endproperty
    a_div8: assert property (p_div8) else $error("divide by eight"); // [RULE6]

    property p_pll_src;
        pllClkEn |-> $past(pllTick);
    endproperty
    a_pll_src: assert property (p_pll_src) else $error("PLL tick"); // [RULE1]

    property p_rc_src;
        fastRcClkEn |-> $past(fastRcTick);
    endproperty
    a_rc_src: assert property (p_rc_src) else $error("fast RC tick"); // [RULE2]

    property p_cfg_others;
        !$past(rstn) |-> pll_multiplier_q == $past(cfgPllMult) && newOsc_q == $past(cfgNewOsc);
    endproperty
    a_cfg_others: assert property (p_cfg_others) else $error("config fields"); // [RULE9]

    property p_fld_wr;
        ctrlOk |=> pll_output_divider_q == $past(wrData[POS_PLL_ODIV +: 3])
            && fastRcDiv_q == $past(wrData[POS_FAST_RC +: 3]);
    endproperty
    a_fld_wr: assert property (p_fld_wr) else $error("field write"); // [RULE1] [RULE2]

    property p_pdiv_taken;
        periphWrOk |=> periphDiv_q == $past(wrData[POS_PERIPH_DIV +: 2]);
    endproperty
    a_pdiv_taken: assert property (p_pdiv_taken) else $error("divisor taken"); // [RULE5]

    property p_rdy_bit;
        $past(rdEn && selCtrl) |-> rdData[POS_PDIV_RDY] == $past(periphRdy);
    endproperty
    a_rdy_bit: assert property (p_rdy_bit) else $error("ready bit"); // [RULE5]

    property p_relock;
        ctrlWr |=> unlock_q == LOCKED;
    endproperty
    a_relock: assert property (p_relock) else $error("relock"); // [RULE8]

    property p_key_needed;
        $rose(unlock_q == UNLOCKED) |-> $past(wrEn && selUnlock && wrData == UNLOCK_KEY2);
    endproperty
    a_key_needed: assert property (p_key_needed) else $error("unlock key"); // [RULE8]

    property p_lock_err_irq;
        lockErr |=> irqStat_q[IRQ_LOCK_ERR];
    endproperty
    a_lock_err_irq: assert property (p_lock_err_irq) else $error("lock event"); // [RULE8]

    property p_sosc_irq;
        soscRise |=> irqStat_q[IRQ_SOSC_UP];
    endproperty
    a_sosc_irq: assert property (p_sosc_irq) else $error("osc event"); // [RULE4]

    property p_pdiv_done;
        periphDone |=> irqStat_q[IRQ_PDIV_DONE];
    endproperty
    a_pdiv_done: assert property (p_pdiv_done) else $error("divisor event"); // [RULE11]

    property p_pend_clear;
        periphDone && !periphStart |=> !pdivPend_q;
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("pending flag"); // [RULE11]

    property p_rdy_settle;
        periphBusy |-> ##[1:8] periphRdy;
    endproperty
    a_rdy_settle: assert property (p_rdy_settle) else $error("ready settle"); // [RULE11]

    property p_no_short;
        periphClkEn && periphLink.active != 3'h0 |=> !periphClkEn;
    endproperty
    a_no_short: assert property (p_no_short) else $error("short pulse"); // [RULE11]

    // divider timing seen from the outside
    property p_pll_div1;
        pllLink.active == 3'h0 && pllTick |=> pllClkEn;
    endproperty
    a_pll_div1: assert property (p_pll_div1) else $error("PLL divide by one"); // [RULE1]

    property p_rc_div1;
        fastRcLink.active == 3'h0 && fastRcTick |=> fastRcClkEn;
    endproperty
    a_rc_div1: assert property (p_rc_div1) else $error("fast RC divide by one"); // [RULE2]

    property p_div2;
        periphClkEn && periphLink.active == 3'h1 |=> !periphClkEn ##1 periphClkEn;
    endproperty
    a_div2: assert property (p_div2) else $error("divide by two"); // [RULE6]

    property p_div4;
        periphClkEn && periphLink.active == 3'h2 |=> (!periphClkEn)[*3] ##1 periphClkEn;
    endproperty
    a_div4: assert property (p_div4) else $error("divide by four"); // [RULE6]

    c_unlocked_write: cover property (ctrlOk);
    c_pdiv_change: cover property (periphDone);
    c_irq: cover property (irq);
    c_sosc_up: cover property (soscRise);
    c_lock_err: cover property (lockErr);
endmodule : osc_ctl

/* tb_osc_ctl.sv */
/*
 * Self-checking bench for the oscillator control block: register port
 * tasks, divider period checks, unlock, interrupt and reset loading.
 * Assumes osc_ctl_pkg compiled first; assertions live in the design.
 */
`timescale 1ns/10ps
module tb_osc_ctl;
    import osc_ctl_pkg::*;
    // ======================================================
    // stimulus and observed signals
    logic        sys_clk      = 1'b0;
    logic        rstn         = 1'b0;
    logic [3:0]  addr         = 4'h0;
    logic [31:0] wrData       = 32'h0;
    logic        wrEn         = 1'b0;
    logic        rdEn         = 1'b0;
    logic [2:0]  cfgPllOdiv   = 3'h2;
    logic [1:0]  cfgPeriphDiv = CFG_PDIV_ERASED;
    logic [2:0]  cfgPllMult   = 3'h5;
    logic [2:0]  cfgNewOsc    = 3'h4;
    logic        cfgSoscEn    = 1'b0;
    logic        pllTick      = 1'b1;
    logic        fastRcTick   = 1'b0;
    logic        soscStable   = 1'b0;
    logic [31:0] rdData;
    logic        pllClkEn;
    logic        fastRcClkEn;
    logic        periphClkEn;
    logic [2:0]  pllMultiplier;
    logic [2:0]  newOscSelect;
    logic        soscEnable;
    logic        irq;
    int          n_mismatch = 0;
    int          checks     = 0;
    int          n;
    int          ex;
    logic [31:0] ctrlExp;

    always #2.5 sys_clk = ~sys_clk;
    // half-rate source proves the fast RC divider counts input ticks
    always @(posedge sys_clk) fastRcTick <= ~fastRcTick;

    osc_ctl osc_ctl_inst (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wrData(wrData),
        .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .cfgPllOdiv(cfgPllOdiv),
        .cfgPeriphDiv(cfgPeriphDiv), .cfgPllMult(cfgPllMult), .cfgNewOsc(cfgNewOsc),
        .cfgSoscEn(cfgSoscEn), .pllTick(pllTick), .fastRcTick(fastRcTick),
        .soscStable(soscStable), .pllClkEn(pllClkEn), .fastRcClkEn(fastRcClkEn),
        .periphClkEn(periphClkEn), .pllMultiplier(pllMultiplier),
        .newOscSelect(newOscSelect), .soscEnable(soscEnable), .irq(irq));

    // ======================================================
    // tasks
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic quiet;
        wrEn <= 1'b0;
        rdEn <= 1'b0;
    endtask : quiet

    // strobe stays up on return so back-to-back writes never toggle it
    task automatic wr(logic [3:0] a, logic [31:0] d);
        addr   <= a;
        wrData <= d;
        wrEn   <= 1'b1;
        rdEn   <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task automatic wr_ctl(logic [31:0] d);
        wr(OFF_UNLOCK, UNLOCK_KEY1);
        wr(OFF_UNLOCK, UNLOCK_KEY2);
        wr(OFF_OSC_CTRL, d);
    endtask : wr_ctl

    task automatic rd(string what, logic [3:0] a, logic [31:0] exp, logic [31:0] msk);
        addr <= a;
        rdEn <= 1'b1;
        wrEn <= 1'b0;
        @(posedge sys_clk);
        rdEn <= 1'b0;
        @(negedge sys_clk);
        check(what, rdData & msk, exp & msk);
        @(posedge sys_clk);
    endtask : rd

    task automatic chk_irq(logic exp);
        quiet();
        @(negedge sys_clk);
        check("irq", {31'h0, irq}, {31'h0, exp});
        @(posedge sys_clk);
    endtask : chk_irq

    // first spans may belong to the old setting; the last one counts
    task automatic period(ref logic en, output int cnt);
        int k;
        quiet();
        for (int p = 0; p < 4; p++) begin
            k = 0;
            do begin
                @(negedge sys_clk);
                k++;
            end while (!en && k < 600);
            cnt = k;
        end
        @(posedge sys_clk);
    endtask : period

    task automatic do_reset;
        rstn <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask : do_reset

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    // ======================================================
    // tests
    initial begin
        do_reset();
        ctrlExp = {2'h0, 3'h2, FAST_RC_RESET, 3'b001, CFG_PDIV_ERASED, 3'h5, 5'h0, 3'h4, 8'h00};
        rd("ctrl reset", OFF_OSC_CTRL, ctrlExp, '1);
        check("mult", {29'h0, pllMultiplier}, 32'h5);
        check("newosc", {29'h0, newOscSelect}, 32'h4);
        period(periphClkEn, n);
        check("periph reset period", n, 8);
        rd("unmapped", 4'h2, 32'h0, '1);
        $display("test reset done");

        wr(OFF_OSC_CTRL, 32'hFFFF_FFFF);
        rd("ctrl locked", OFF_OSC_CTRL, ctrlExp, '1);
        wr(OFF_UNLOCK, UNLOCK_KEY1);
        wr(OFF_UNLOCK, UNLOCK_KEY2);
        rd("unlock open", OFF_UNLOCK, 32'h1, '1);
        wr(OFF_UNLOCK, UNLOCK_KEY1);
        wr(OFF_UNLOCK, UNLOCK_KEY2);
        wr(OFF_OSC_CTRL, 32'hFFFF_FFFF);
        rd("ctrl relocked", OFF_OSC_CTRL, ctrlExp, '1);
        rd("lock err", OFF_IRQ_STAT, 32'h4, 32'h4);
        chk_irq(1'b0);
        wr(OFF_IRQ_MASK, 32'h4);
        chk_irq(1'b1);
        wr(OFF_IRQ_STAT, 32'h4);
        chk_irq(1'b0);
        $display("test lock done");

        for (int c = 0; c < 8; c++) begin
            ctrlExp[29:27] = 3'(c);
            ctrlExp[26:24] = 3'(c);
            wr_ctl(ctrlExp);
            rd("ctrl divs", OFF_OSC_CTRL, ctrlExp, '1);
            ex = (c == 7) ? 256 : (1 << c);
            period(pllClkEn, n);
            check("pll period", n, ex);
            period(fastRcClkEn, n);
            check("fast rc period", n, 2 * ex);
        end
        $display("test dividers done");

        for (int d = 0; d < 4; d++) begin
            ctrlExp[20:19] = 2'(d);
            wr_ctl(ctrlExp);
            period(periphClkEn, n);
            check("periph period", n, 1 << d);
            rd("ctrl periph", OFF_OSC_CTRL, ctrlExp, '1);
        end
        quiet();
        do begin
            @(negedge sys_clk);
        end while (!periphClkEn);
        @(posedge sys_clk);
        ctrlExp[20:19] = 2'h0;
        wr_ctl(ctrlExp);
        wr_ctl(ctrlExp | 32'h0008_0000);
        rd("ctrl gated", OFF_OSC_CTRL, ctrlExp, 32'hFFDF_FFFF);
        period(periphClkEn, n);
        check("periph gated", n, 1);
        rd("ctrl ready", OFF_OSC_CTRL, ctrlExp, '1);
        rd("pdiv done", OFF_IRQ_STAT, 32'h2, 32'h2);
        $display("test periph done");

        soscStable <= 1'b1;
        rd("sosc off", OFF_OSC_CTRL, ctrlExp, '1);
        ctrlExp[1] = 1'b1;
        ctrlExp[22] = 1'b1;
        wr_ctl(ctrlExp);
        quiet();
        repeat (2) @(posedge sys_clk);
        rd("sosc ready", OFF_OSC_CTRL, ctrlExp, '1);
        rd("sosc event", OFF_IRQ_STAT, 32'h1, 32'h1);
        soscStable <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd("sosc lost", OFF_OSC_CTRL, ctrlExp & 32'hFFBF_FFFF, '1);
        $display("test sosc done");

        cfgPllOdiv   <= 3'h6;
        cfgPeriphDiv <= 2'h1;
        cfgPllMult   <= 3'h2;
        cfgNewOsc    <= 3'h1;
        cfgSoscEn    <= 1'b1;
        do_reset();
        ctrlExp = {2'h0, 3'h6, FAST_RC_RESET, 3'b001, 2'h1, 3'h2, 5'h0, 3'h1, 8'h02};
        rd("ctrl cfg", OFF_OSC_CTRL, ctrlExp, '1);
        check("sosc en", {31'h0, soscEnable}, 32'h1);
        period(periphClkEn, n);
        check("periph cfg period", n, 2);
        $display("test second reset done");
        give_verdict();
    end

    initial begin
        #400000;
        $display("watchdog expired");
        n_mismatch++;
        give_verdict();
    end
endmodule : tb_osc_ctl
